// ---- idl_consts.svh ----
// constants for the interlock diagnostic logic and its serial gateway
`ifndef IDL_CONSTS_SVH
`define IDL_CONSTS_SVH

`define IDL_CLK_HZ         100000000
`define IDL_MAX_DEV        31
`define IDL_SLOT_BITS      9

// request byte fields
`define IDL_REQ_MAGNET     0
`define IDL_REQ_ERR_RST    7

// response byte fields
`define IDL_RSP_SAFE_ON    0
`define IDL_RSP_CLOSED     1
`define IDL_RSP_LOCKED     2
`define IDL_RSP_INPUTS     4
`define IDL_RSP_ACT_OK     5
`define IDL_RSP_WARN       6
`define IDL_RSP_ERR        7

// flash codes, 7 means steady light
`define IDL_CODE_NONE      3'h0
`define IDL_CODE_FIRST     3'h1
`define IDL_CODE_SECOND    3'h2
`define IDL_CODE_CROSS     3'h3
`define IDL_CODE_TEMP      3'h4
`define IDL_CODE_ACTUATOR  3'h5
`define IDL_CODE_HANDLE    3'h6
`define IDL_CODE_STEADY    3'h7

// timing
`define IDL_WARN_MIN       30
`define IDL_FLASH_ON_MS    250
`define IDL_FLASH_OFF_MS   250
`define IDL_FLASH_PAUSE_MS 1500
`define IDL_COMM_TMO_MS    100
`define IDL_GW_GAP_CYC     16
`define IDL_GW_TMO_CYC     1024

// gateway register map
`define IDL_GW_CTRL        12'h000
`define IDL_GW_STAT        12'h004
`define IDL_GW_REQ_BASE    12'h100
`define IDL_GW_RSP_BASE    12'h200
`define IDL_GW_CTRL_EN     0
`define IDL_GW_CTRL_CNT_LO 8
`define IDL_GW_CNT_RESET   5'h01
`define IDL_GW_STAT_BUSY   0
`define IDL_GW_STAT_TMO    1
`define IDL_GW_STAT_FRM_LO 16

`endif

// ---- idl_pkg.sv ----
// types for the interlock diagnostic logic and its serial gateway
package idl_pkg;

    typedef enum logic [3:0] {
        LK_IDLE   = 4'h1,
        LK_TAKE   = 4'h2,
        LK_PASS   = 4'h4,
        LK_APPEND = 4'h8
    } idl_link_type;

    typedef enum logic [3:0] {
        FL_IDLE  = 4'h1,
        FL_ON    = 4'h2,
        FL_OFF   = 4'h4,
        FL_PAUSE = 4'h8
    } idl_flash_type;

    typedef enum logic [2:0] {
        GW_GAP  = 3'h1,
        GW_SEND = 3'h2,
        GW_WAIT = 3'h4
    } idl_gw_type;

    typedef struct packed {
        idl_link_type  lk;
        logic [3:0]    bit_cnt;
        logic [7:0]    sh;
        logic [7:0]    req;
        logic          out;
        logic [31:0]   comm_cnt;
        logic          comm_err;
        logic [39:0]   warn_cnt;
        logic          err;
        logic          opened;
        idl_flash_type fl;
        logic [31:0]   fl_cnt;
        logic [2:0]    pulses;
        logic          safe;
        logic          diag;
        logic          led;
    } idl_dev_type;

    typedef struct packed {
        idl_gw_type       st;
        logic             en;
        logic [4:0]       count;
        logic [30:0][7:0] req;
        logic [30:0][7:0] rsp;
        logic [4:0]       tx_idx;
        logic [3:0]       tx_bit;
        logic [8:0]       tx_sh;
        logic             out;
        logic             rx_busy;
        logic [2:0]       rx_bit;
        logic [7:0]       rx_sh;
        logic [4:0]       rx_idx;
        logic [15:0]      tmo;
        logic             tmo_err;
        logic [15:0]      frames;
        logic [31:0]      prdata;
    } idl_gw_state_type;

endpackage

// ---- idl_sd_if.sv ----
// one segment of the serial diagnostic chain
`timescale 1ns/1ps
interface idl_sd_if;
    logic sd;
    modport drv (output sd);
    modport rcv (input sd);
endinterface

// ---- idl_lock_dev.sv ----
// interlock diagnostic and fault logic, device end of the serial chain
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "idl_consts.svh"
module idl_lock_dev #(
    parameter bit          SERIAL_VARIANT  = 1'b1,
    parameter bit          POWER_TO_LOCK   = 1'b0,
    parameter logic [39:0] WARN_CYC        =
        40'(64'(`IDL_WARN_MIN) * 64'd60 * 64'(`IDL_CLK_HZ)),
    parameter int unsigned FLASH_ON_CYC    = `IDL_FLASH_ON_MS * (`IDL_CLK_HZ / 1000),
    parameter int unsigned FLASH_OFF_CYC   = `IDL_FLASH_OFF_MS * (`IDL_CLK_HZ / 1000),
    parameter int unsigned FLASH_PAUSE_CYC = `IDL_FLASH_PAUSE_MS * (`IDL_CLK_HZ / 1000),
    parameter int unsigned COMM_TMO_CYC    = `IDL_COMM_TMO_MS * (`IDL_CLK_HZ / 1000)
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic SYS_RST,
    // serial diagnostic chain
    idl_sd_if.rcv     UP_LINK,
    idl_sd_if.drv     DOWN_LINK,
    // guard sensing and control
    input  wire logic GUARD_CLOSED,
    input  wire logic ACTUATOR_VALID,
    input  wire logic FIRST_SAFETY_INPUT,
    input  wire logic SECOND_SAFETY_INPUT,
    input  wire logic SOLENOID_CTRL,
    // fault sensing
    input  wire logic FLT_FIRST_OUTPUT,
    input  wire logic FLT_SECOND_OUTPUT,
    input  wire logic FLT_CROSS_WIRE,
    input  wire logic FLT_OVERTEMP,
    input  wire logic FLT_ACTUATOR,
    input  wire logic FLT_HANDLE,
    input  wire logic FLT_INTERNAL,
    // outputs
    output logic      FIRST_SAFETY_OUTPUT,
    output logic      SECOND_SAFETY_OUTPUT,
    output logic      DIAG_OUT,
    output logic      SOLENOID_DRIVE,
    output logic      RED_LED,
    output logic      COMM_FAULT
);

    idl_pkg::idl_dev_type r_q;
    idl_pkg::idl_dev_type r_d;

    logic       warn;
    logic       hard;
    logic       magnet;
    logic       lock_cmd;
    logic       locked;
    logic       trip;
    logic       clear_ok;
    logic       rst_fall;
    logic [2:0] code;
    logic [7:0] resp;

    assign warn = FLT_FIRST_OUTPUT | FLT_SECOND_OUTPUT | FLT_CROSS_WIRE | FLT_OVERTEMP;
    assign hard = FLT_INTERNAL | FLT_ACTUATOR | FLT_HANDLE;

    assign magnet   = SERIAL_VARIANT ? r_q.req[`IDL_REQ_MAGNET] : SOLENOID_CTRL;
    assign lock_cmd = POWER_TO_LOCK ? magnet : !magnet;
    assign locked   = GUARD_CLOSED & ACTUATOR_VALID & lock_cmd & !FLT_HANDLE;

    assign trip     = warn && (r_q.warn_cnt == WARN_CYC - 40'h1);
    assign clear_ok = !hard && !warn;

    always_comb begin
        if (FLT_INTERNAL) begin
            code = `IDL_CODE_STEADY;
        end else if (FLT_HANDLE) begin
            code = `IDL_CODE_HANDLE;
        end else if (FLT_ACTUATOR) begin
            code = `IDL_CODE_ACTUATOR;
        end else if (FLT_OVERTEMP) begin
            code = `IDL_CODE_TEMP;
        end else if (FLT_CROSS_WIRE || (FLT_FIRST_OUTPUT && FLT_SECOND_OUTPUT)) begin
            code = `IDL_CODE_CROSS;
        end else if (FLT_SECOND_OUTPUT) begin
            code = `IDL_CODE_SECOND;
        end else if (FLT_FIRST_OUTPUT) begin
            code = `IDL_CODE_FIRST;
        end else begin
            code = `IDL_CODE_NONE;
        end
    end

    always_comb begin
        resp                   = 8'h00;
        resp[`IDL_RSP_SAFE_ON] = r_q.safe;
        resp[`IDL_RSP_CLOSED]  = GUARD_CLOSED;
        resp[`IDL_RSP_LOCKED]  = locked;
        resp[`IDL_RSP_INPUTS]  = FIRST_SAFETY_INPUT & SECOND_SAFETY_INPUT;
        resp[`IDL_RSP_ACT_OK]  = ACTUATOR_VALID;
        resp[`IDL_RSP_WARN]    = warn;
        resp[`IDL_RSP_ERR]     = r_q.err;
    end

    always_comb begin
        r_d      = r_q;
        rst_fall = 1'b0;

        // chain slot handling, one bit per clock
        if (SERIAL_VARIANT) begin
            case (r_q.lk)
                idl_pkg::LK_IDLE: begin
                    r_d.out     = 1'b0;
                    r_d.bit_cnt = 4'h0;
                    if (UP_LINK.sd) begin
                        r_d.lk = idl_pkg::LK_TAKE;
                    end
                end
                idl_pkg::LK_TAKE: begin
                    r_d.out     = 1'b0;
                    r_d.sh      = {r_q.sh[6:0], UP_LINK.sd};
                    r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                    if (r_q.bit_cnt == 4'h7) begin
                        // own request byte is the first slot
                        r_d.req      = {r_q.sh[6:0], UP_LINK.sd};
                        rst_fall     = r_q.req[`IDL_REQ_ERR_RST] & !r_d.req[`IDL_REQ_ERR_RST];
                        r_d.comm_cnt = 32'h0;
                        r_d.comm_err = 1'b0;
                        r_d.bit_cnt  = 4'h0;
                        r_d.lk       = idl_pkg::LK_PASS;
                    end
                end
                idl_pkg::LK_PASS: begin
                    r_d.out     = UP_LINK.sd;
                    r_d.bit_cnt = (r_q.bit_cnt == 4'(`IDL_SLOT_BITS - 1)) ? 4'h0
                                                                           : r_q.bit_cnt + 4'h1;
                    // a missing slot marker ends the frame: append own slot
                    if (r_q.bit_cnt == 4'h0 && !UP_LINK.sd) begin
                        r_d.out     = 1'b1;
                        r_d.sh      = resp;
                        r_d.bit_cnt = 4'h0;
                        r_d.lk      = idl_pkg::LK_APPEND;
                    end
                end
                idl_pkg::LK_APPEND: begin
                    r_d.out     = r_q.sh[7];
                    r_d.sh      = {r_q.sh[6:0], 1'b0};
                    r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                    if (r_q.bit_cnt == 4'h7) begin
                        r_d.lk = idl_pkg::LK_IDLE;
                    end
                end
                default: begin
                    r_d.lk = idl_pkg::LK_IDLE;
                end
            endcase

            // watchdog only flags, request stays as it was
            if (r_q.lk != idl_pkg::LK_TAKE || r_q.bit_cnt != 4'h7) begin
                if (r_q.comm_cnt == 32'(COMM_TMO_CYC - 1)) begin
                    r_d.comm_err = 1'b1;
                end else begin
                    r_d.comm_cnt = r_q.comm_cnt + 32'h1;
                end
            end
        end

        // warning timer runs only while warned
        if (!warn) begin
            r_d.warn_cnt = 40'h0;
        end else if (!trip) begin
            r_d.warn_cnt = r_q.warn_cnt + 40'h1;
        end

        // opening seen once causes are gone
        if (!r_q.err) begin
            r_d.opened = 1'b0;
        end else if (clear_ok && !GUARD_CLOSED) begin
            r_d.opened = 1'b1;
        end

        // serial clearing; conventional clearing; set wins
        if (SERIAL_VARIANT) begin
            r_d.err = (r_q.err && !(clear_ok && (rst_fall || !GUARD_CLOSED))) || hard || trip;
        end else begin
            r_d.err = (r_q.err && !(clear_ok && r_q.opened && GUARD_CLOSED)) || hard || trip;
        end

        // hard faults drop the outputs at once
        r_d.safe = locked & FIRST_SAFETY_INPUT & SECOND_SAFETY_INPUT
                   & !r_q.err & !hard & !trip;
        r_d.diag = !SERIAL_VARIANT & locked & !warn & !r_q.err & !hard;

        // pulse groups with a trailing pause
        case (r_q.fl)
            idl_pkg::FL_IDLE: begin
                r_d.led = (code == `IDL_CODE_STEADY);
                if (code != `IDL_CODE_NONE && code != `IDL_CODE_STEADY) begin
                    r_d.led    = 1'b1;
                    r_d.pulses = code;
                    r_d.fl_cnt = 32'(FLASH_ON_CYC - 1);
                    r_d.fl     = idl_pkg::FL_ON;
                end
            end
            idl_pkg::FL_ON: begin
                r_d.fl_cnt = r_q.fl_cnt - 32'h1;
                if (r_q.fl_cnt == 32'h0) begin
                    r_d.led    = 1'b0;
                    r_d.pulses = r_q.pulses - 3'h1;
                    r_d.fl_cnt = 32'(FLASH_OFF_CYC - 1);
                    r_d.fl     = idl_pkg::FL_OFF;
                end
            end
            idl_pkg::FL_OFF: begin
                r_d.fl_cnt = r_q.fl_cnt - 32'h1;
                if (r_q.fl_cnt == 32'h0) begin
                    if (r_q.pulses == 3'h0) begin
                        r_d.fl_cnt = 32'(FLASH_PAUSE_CYC - 1);
                        r_d.fl     = idl_pkg::FL_PAUSE;
                    end else begin
                        r_d.led    = 1'b1;
                        r_d.fl_cnt = 32'(FLASH_ON_CYC - 1);
                        r_d.fl     = idl_pkg::FL_ON;
                    end
                end
            end
            idl_pkg::FL_PAUSE: begin
                r_d.fl_cnt = r_q.fl_cnt - 32'h1;
                if (r_q.fl_cnt == 32'h0) begin
                    r_d.fl = idl_pkg::FL_IDLE;
                end
            end
            default: begin
                r_d.fl = idl_pkg::FL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            r_q    <= '0;
            r_q.lk <= idl_pkg::LK_IDLE;
            r_q.fl <= idl_pkg::FL_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    // chain output only in the serial variant
    assign DOWN_LINK.sd         = SERIAL_VARIANT & r_q.out;
    assign FIRST_SAFETY_OUTPUT  = r_q.safe;
    assign SECOND_SAFETY_OUTPUT = r_q.safe;
    assign DIAG_OUT             = r_q.diag;
    assign SOLENOID_DRIVE       = magnet;
    assign RED_LED              = r_q.led;
    assign COMM_FAULT           = r_q.comm_err;

endmodule

// ---- idl_sd_gateway.sv ----
// serial diagnostic gateway: chain master with an APB register slave
`timescale 1ns/1ps
`include "idl_consts.svh"
module idl_sd_gateway #(
    parameter int unsigned GAP_CYC = `IDL_GW_GAP_CYC,
    parameter int unsigned TMO_CYC = `IDL_GW_TMO_CYC
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // serial diagnostic chain
    idl_sd_if.drv            TO_CHAIN,
    idl_sd_if.rcv            FROM_CHAIN,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    idl_pkg::idl_gw_state_type r_q;
    idl_pkg::idl_gw_state_type r_d;

    logic       is_ctrl;
    logic       is_stat;
    logic       is_req;
    logic       is_rsp;
    logic [4:0] idx;
    logic       access;

    assign idx    = PADDR[6:2];
    assign access = PSEL & PENABLE;

    always_comb begin
        is_ctrl = 1'b0;
        is_stat = 1'b0;
        is_req  = 1'b0;
        is_rsp  = 1'b0;
        if (PADDR == `IDL_GW_CTRL) begin
            is_ctrl = 1'b1;
        end else if (PADDR == `IDL_GW_STAT) begin
            is_stat = 1'b1;
        end else if (PADDR[11:7] == 5'(`IDL_GW_REQ_BASE >> 7) && PADDR[1:0] == 2'h0
                     && idx < 5'(`IDL_MAX_DEV)) begin
            is_req = 1'b1;
        end else if (PADDR[11:7] == 5'(`IDL_GW_RSP_BASE >> 7) && PADDR[1:0] == 2'h0
                     && idx < 5'(`IDL_MAX_DEV)) begin
            is_rsp = 1'b1;
        end
    end

    always_comb begin
        r_d = r_q;

        // read data captured in the setup cycle
        if (PSEL && !PENABLE) begin
            r_d.prdata = 32'h0;
            if (is_ctrl) begin
                r_d.prdata[`IDL_GW_CTRL_EN] = r_q.en;
                r_d.prdata[`IDL_GW_CTRL_CNT_LO +: 5] = r_q.count;
            end else if (is_stat) begin
                r_d.prdata[`IDL_GW_STAT_BUSY] = (r_q.st != idl_pkg::GW_GAP);
                r_d.prdata[`IDL_GW_STAT_TMO] = r_q.tmo_err;
                r_d.prdata[`IDL_GW_STAT_FRM_LO +: 16] = r_q.frames;
            end else if (is_req) begin
                r_d.prdata[7:0] = r_q.req[idx];
            end else if (is_rsp) begin
                r_d.prdata[7:0] = r_q.rsp[idx];
            end
        end

        if (access && PWRITE) begin
            if (is_ctrl) begin
                r_d.en = PWDATA[`IDL_GW_CTRL_EN];
                r_d.count = (PWDATA[`IDL_GW_CTRL_CNT_LO +: 5] > 5'(`IDL_MAX_DEV))
                            ? 5'(`IDL_MAX_DEV) : PWDATA[`IDL_GW_CTRL_CNT_LO +: 5];
            end else if (is_stat) begin
                r_d.tmo_err = r_q.tmo_err & !PWDATA[`IDL_GW_STAT_TMO];
            end else if (is_req) begin
                r_d.req[idx] = PWDATA[7:0];
            end
        end

        if (r_q.st != idl_pkg::GW_GAP) begin
            if (!r_q.rx_busy) begin
                r_d.rx_busy = FROM_CHAIN.sd;
                r_d.rx_bit  = 3'h0;
            end else begin
                r_d.rx_sh  = {r_q.rx_sh[6:0], FROM_CHAIN.sd};
                r_d.rx_bit = r_q.rx_bit + 3'h1;
                if (r_q.rx_bit == 3'h7) begin
                    r_d.rsp[r_q.rx_idx] = {r_q.rx_sh[6:0], FROM_CHAIN.sd};
                    r_d.rx_idx          = r_q.rx_idx + 5'h1;
                    r_d.rx_busy         = 1'b0;
                end
            end
        end

        case (r_q.st)
            idl_pkg::GW_GAP: begin
                r_d.out = 1'b0;
                r_d.tmo = r_q.tmo + 16'h1;
                if (r_q.tmo >= 16'(GAP_CYC - 1) && r_q.en && r_q.count != 5'h0) begin
                    r_d.tx_sh   = {1'b1, r_q.req[0]};
                    r_d.tx_idx  = 5'h0;
                    r_d.tx_bit  = 4'h0;
                    r_d.rx_idx  = 5'h0;
                    r_d.rx_busy = 1'b0;
                    r_d.tmo     = 16'h0;
                    r_d.st      = idl_pkg::GW_SEND;
                end
            end
            idl_pkg::GW_SEND: begin
                r_d.out    = r_q.tx_sh[8];
                r_d.tx_sh  = {r_q.tx_sh[7:0], 1'b0};
                r_d.tx_bit = r_q.tx_bit + 4'h1;
                if (r_q.tx_bit == 4'(`IDL_SLOT_BITS - 1)) begin
                    r_d.tx_bit = 4'h0;
                    r_d.tx_idx = r_q.tx_idx + 5'h1;
                    r_d.tx_sh  = {1'b1, r_q.req[r_q.tx_idx + 5'h1]};
                    if (r_q.tx_idx == r_q.count - 5'h1) begin
                        r_d.st = idl_pkg::GW_WAIT;
                    end
                end
            end
            idl_pkg::GW_WAIT: begin
                r_d.out = 1'b0;
                r_d.tmo = r_q.tmo + 16'h1;
                if (r_d.rx_idx == r_q.count) begin
                    r_d.frames = r_q.frames + 16'h1;
                    r_d.tmo    = 16'h0;
                    r_d.st     = idl_pkg::GW_GAP;
                end else if (r_q.tmo == 16'(TMO_CYC - 1)) begin
                    r_d.tmo_err = 1'b1;
                    r_d.tmo     = 16'h0;
                    r_d.st      = idl_pkg::GW_GAP;
                end
            end
            default: begin
                r_d.st = idl_pkg::GW_GAP;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            r_q       <= '0;
            r_q.st    <= idl_pkg::GW_GAP;
            r_q.count <= `IDL_GW_CNT_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    assign TO_CHAIN.sd = r_q.out;
    assign PRDATA      = r_q.prdata;
    assign PREADY      = 1'b1;
    assign PSLVERR     = access & !(is_ctrl | is_stat | is_req | (is_rsp & !PWRITE));

endmodule

// ---- idl_chain_props.sv ----
// assertions on the serial chain and the device outputs
`timescale 1ns/1ps
module idl_chain_props #(
    parameter int WARN_CYC = 200
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // chain segments
    input wire logic sd_up,
    input wire logic sd_dn,
    // device ports
    input wire logic FIRST_SAFETY_OUTPUT,
    input wire logic SECOND_SAFETY_OUTPUT,
    input wire logic DIAG_OUT,
    input wire logic RED_LED,
    input wire logic FLT_INTERNAL,
    input wire logic FLT_HANDLE,
    input wire logic FLT_ACTUATOR,
    input wire logic FLT_OVERTEMP
);
    logic [9:0] run_q;
    logic [9:0] run_d;

    // length of the current overtemperature run
    always_comb begin
        run_d = FLT_OVERTEMP ? run_q + 10'h001 : 10'h000;
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            run_q <= 10'h000;
        end else begin
            run_q <= run_d;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    // a marker after an idle stretch opens a slot
    sequence up_frame;
        (!sd_up)[*8] ##1 sd_up;
    endsequence
    sequence dn_frame;
        (!sd_dn)[*8] ##1 sd_dn;
    endsequence

    a_gw_slot_len: assert property (up_frame |-> ##9 !sd_up)
        else $error("request frame longer than one slot");
    a_dev_answer_time: assert property (up_frame |-> ##10 sd_dn)
        else $error("device slot not started ten cycles after request");
    a_dev_slot_len: assert property (dn_frame |-> ##9 !sd_dn)
        else $error("response slot not one byte long");
    a_hard_fault_drop: assert property ((FLT_INTERNAL || FLT_HANDLE || FLT_ACTUATOR)
        |=> !FIRST_SAFETY_OUTPUT && !SECOND_SAFETY_OUTPUT)
        else $error("safety outputs on after hard fault");
    a_internal_steady: assert property (FLT_INTERNAL[*8] |-> RED_LED)
        else $error("red light not steady on internal error");
    a_diag_serial_zero: assert property (!DIAG_OUT)
        else $error("diag output driven in serial variant");
    a_warn_shutdown: assert property (run_q >= WARN_CYC + 2 |-> !FIRST_SAFETY_OUTPUT)
        else $error("outputs on after warning expiry");
    a_pulse_width: assert property ($rose(RED_LED) && !FLT_INTERNAL
        |-> RED_LED[*4] ##1 !RED_LED)
        else $error("flash pulse width wrong");
endmodule

// ---- testbench.sv ----
// bench: gateway and one interlock device joined on the chain
`timescale 1ns/1ps
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module testbench;
    logic        CLK;
    logic        SYS_RST;
    logic        psel, penable, pwrite, e, guard;
    logic [11:0] paddr;
    logic [31:0] pwdata, q, prdata;
    logic        pready, pslverr;
    logic [6:0]  flt;
    logic        act, in1, in2, solc;
    wire         fo, so, diag, sol, led, comm;
    int          errors, n_compared, ticks, n, i;
    // rows: fault inputs, {err, warn, safe}, flash pulses
    logic [12:0] rows [8] = '{13'h0008, 13'h0059, 13'h009A, 13'h011B,
                              13'h00DB, 13'h021C, 13'h0425, 13'h0826};
    idl_sd_if g2d ();
    idl_sd_if d2g ();
    idl_sd_gateway u_idl_sd_gateway (.CLK(CLK), .SYS_RST(SYS_RST), .TO_CHAIN(g2d),
        .FROM_CHAIN(d2g), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    idl_lock_dev #(.WARN_CYC(40'hC8), .FLASH_ON_CYC(4), .FLASH_OFF_CYC(4),
        .FLASH_PAUSE_CYC(12), .COMM_TMO_CYC(300)) u_idl_lock_dev (.CLK(CLK),
        .SYS_RST(SYS_RST), .UP_LINK(g2d), .DOWN_LINK(d2g), .GUARD_CLOSED(guard),
        .ACTUATOR_VALID(act), .FIRST_SAFETY_INPUT(in1), .SECOND_SAFETY_INPUT(in2),
        .SOLENOID_CTRL(solc), .FLT_FIRST_OUTPUT(flt[0]), .FLT_SECOND_OUTPUT(flt[1]),
        .FLT_CROSS_WIRE(flt[2]), .FLT_OVERTEMP(flt[3]), .FLT_ACTUATOR(flt[4]),
        .FLT_HANDLE(flt[5]), .FLT_INTERNAL(flt[6]), .FIRST_SAFETY_OUTPUT(fo),
        .SECOND_SAFETY_OUTPUT(so), .DIAG_OUT(diag), .SOLENOID_DRIVE(sol),
        .RED_LED(led), .COMM_FAULT(comm));
    idl_chain_props u_props (.CLK(CLK), .SYS_RST(SYS_RST),
        .sd_up(g2d.sd), .sd_dn(d2g.sd), .FIRST_SAFETY_OUTPUT(fo), .SECOND_SAFETY_OUTPUT(so),
        .DIAG_OUT(diag), .RED_LED(led), .FLT_INTERNAL(flt[6]), .FLT_HANDLE(flt[5]),
        .FLT_ACTUATOR(flt[4]), .FLT_OVERTEMP(flt[3]));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic print_verdict();
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge CLK) begin
        ticks++;
        if (ticks == 60000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK);
        penable <= 1'b1;
        do @(posedge CLK); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for a pause, then counts the pulses of one group
    task automatic pulses();
        int   off, t;
        logic p;
        n = 0;
        off = 0;
        p = 1'b0;
        for (t = 0; t < 200 && off < 6; t++) begin
            @(negedge CLK);
            off = led ? 0 : off + 1;
        end
        off = 0;
        for (t = 0; t < 200 && (off < 6 || (n == 0 && t < 80)); t++) begin
            @(negedge CLK);
            n += int'(led && !p);
            p = led;
            off = led ? 0 : off + 1;
        end
    endtask

    // error reset bit taken from 1 to 0
    task automatic clear_err();
        flt <= 7'h00;
        apb(1'b1, 12'h100, 32'h80);
        cyc(80);
        apb(1'b1, 12'h100, 32'h00);
        cyc(80);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        SYS_RST = 1'b1;
        guard = 1'b1;
        flt = 7'h00;
        {act, in1, in2, solc} = 4'hE;
        cyc(2);
        @(negedge CLK);
        `CHK({fo, so, led}, 3'h0)
        cyc(2);
        SYS_RST <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        `CHK(q, 32'h00000100)
        apb(1'b1, 12'h000, 32'h101);
        cyc(100);
        for (i = 0; i < 8; i++) begin
            flt <= rows[i][12:6];
            cyc(50);
            pulses();
            apb(1'b0, 12'h200, 32'h0);
            `CHK({q[7:6], q[0]}, rows[i][5:3])
            `CHK(n[2:0], rows[i][2:0])
            clear_err();
        end
        flt <= 7'h08;
        cyc(150);
        flt <= 7'h00;
        cyc(10);
        flt <= 7'h08;
        cyc(150);
        @(negedge CLK);
        `CHK(fo, 1'b1)
        cyc(100);
        @(negedge CLK);
        `CHK(fo, 1'b0)
        @(posedge CLK);
        flt <= 7'h00;
        cyc(80);
        apb(1'b0, 12'h200, 32'h0);
        `CHK({q[7:6], q[0]}, 3'h4)
        guard <= 1'b0;
        cyc(20);
        guard <= 1'b1;
        cyc(100);
        apb(1'b0, 12'h200, 32'h0);
        `CHK(q[7], 1'b0)
        apb(1'b1, 12'h100, 32'h01);
        cyc(80);
        @(negedge CLK);
        `CHK({sol, fo}, 2'h2)
        apb(1'b1, 12'h000, 32'h100);
        cyc(400);
        @(negedge CLK);
        `CHK({comm, sol}, 2'h3)
        apb(1'b0, 12'h17C, 32'h0);
        `CHK({e, q}, 33'h100000000)
        apb(1'b1, 12'h200, 32'hFF);
        `CHK(e, 1'b1)
        apb(1'b0, 12'h004, 32'h0);
        `CHK(q[1:0], 2'h0)
        apb(1'b1, 12'h100, 32'h00);
        apb(1'b1, 12'h000, 32'h101);
        {act, in1, in2, solc} <= 4'h1;
        cyc(100);
        apb(1'b0, 12'h200, 32'h0);
        `CHK({q[5:4], q[0], comm}, 4'h0)
        `CHK(sol, 1'b0)
        {act, in1, in2, solc} <= 4'hE;
        cyc(80);
        @(negedge CLK);
        `CHK(fo, 1'b1)
        @(posedge CLK);
        flt <= 7'h40;
        cyc(2);
        @(negedge CLK);
        `CHK({fo, so, diag}, 3'h0)
        cyc(20);
        @(negedge CLK);
        `CHK(led, 1'b1)
        print_verdict();
    end
endmodule
